// File: inc/asu_regs.svh
// register indices, field positions, reset values and timing counts
// assumes: included by bare name; definitions only
`ifndef ASU_REGS_SVH
`define ASU_REGS_SVH
// register indices, byte address is four times the index
`define ASU_IDX_CTRL1   6'h24
`define ASU_IDX_STATUS  6'h25
`define ASU_IDX_CTRL2   6'h26
`define ASU_IDX_TXHOLD  6'h27
`define ASU_IDX_RXHOLD  6'h28
`define ASU_IDX_TMATCH  6'h29
// line_control_one fields
`define ASU_C1_TXEN     7
`define ASU_C1_RXEN     6
`define ASU_C1_STOP2    5
`define ASU_C1_PARON    4
`define ASU_C1_EVEN     3
// line_control_two fields
`define ASU_C2_FLT_HI   4
`define ASU_C2_FLT_LO   3
`define ASU_C2_RXSTOP2  0
// serial_status bit of the overrun flag
`define ASU_SR_OERR     5
// reset values
`define ASU_CTRL1_RST   8'h00
`define ASU_CTRL2_RST   8'h00
`define ASU_TMATCH_RST  8'h01
// rate selection
`define ASU_RATE_LAST   3'h5
`define ASU_RATE_TIMER  3'h6
// oversampling and divider timing
`define ASU_CLK_HZ      250000000
`define ASU_TOP_BAUD    76800
`define ASU_OVERSAMPLE  16
`define ASU_BASE_DIV    (`ASU_CLK_HZ / (`ASU_TOP_BAUD * `ASU_OVERSAMPLE))
`define ASU_OS_FIRST    4'h7
`define ASU_OS_LAST     4'h9
`define ASU_OS_END      4'hf
// noise rejection widths in clock periods
`define ASU_FLT_SHORT   7'h1f
`define ASU_FLT_MID     7'h3f
`define ASU_FLT_LONG    7'h7f
`endif

// File: inc/asu_pkg.sv
// types shared by the serial block: bus carriers, states, decode codes
// assumes: compiled before every module of the block
package asu_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } asu_apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } asu_apb_rsp_t;
   typedef enum logic [2:0] {
      ASU_SEL_NONE = 3'b000, ASU_SEL_C1 = 3'b001, ASU_SEL_SR = 3'b010,
      ASU_SEL_C2 = 3'b011, ASU_SEL_TXH = 3'b100, ASU_SEL_RXH = 3'b101,
      ASU_SEL_TM = 3'b110
   } asu_sel_t;
   typedef enum logic [2:0] {
      ASU_IDLE = 3'b000, ASU_START = 3'b001, ASU_DATA = 3'b010,
      ASU_PAR = 3'b011, ASU_STOP = 3'b100
   } asu_bit_st_t;
   typedef struct packed {
      logic [7:0]  lcr1;
      logic [7:0]  lcr2;
      logic [7:0]  tmv;
      logic [7:0]  tx_hold;
      logic [7:0]  tx_sh;
      asu_bit_st_t tx_st;
      logic [3:0]  tx_os;
      logic [2:0]  tx_bit;
      logic        tx_par;
      logic        out;
      logic [7:0]  rx_hold;
      logic [7:0]  rx_sh;
      asu_bit_st_t rx_st;
      logic [3:0]  rx_os;
      logic [2:0]  rx_bit;
      logic [1:0]  rx_smp;
      logic        rx_pbad;
      logic        rx_fbad;
      logic        pbad;
      logic        fbad;
      logic        oerr;
      logic        rbfl;
      logic        done;
      logic        tbmt;
      logic        arm_tx;
      logic        arm_rx;
      logic        oerr_seen;
      logic        tx_irq;
      logic        rx_irq;
      logic [31:0] rdata;
      logic        err;
   } asu_state_t;
   typedef struct packed {
      logic [6:0] cnt;
      logic       out;
   } asu_flt_t;
endpackage

// File: hw/asu_baud_gen.sv
// oversample tick generator: sixteen ticks per bit
// assumes: rate settings change only while both directions are idle
`timescale 1ns/1ns
`include "asu_regs.svh"
module asu_baud_gen #(
   parameter logic [15:0] BASE_DIV = 16'(`ASU_BASE_DIV)
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // rate settings
   input  wire logic [2:0] rate_sel,
   input  wire logic [7:0] match_val,
   // oversample tick
   output logic            tick
);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic [15:0] limit;
   logic        run;

   // fixed codes halve the rate per step; the timer code divides by match
   always_comb begin
      run   = 1'b1;
      limit = 16'h0000;
      if (rate_sel <= `ASU_RATE_LAST) begin
         limit = (BASE_DIV << rate_sel) - 16'h0001;
      end else if (rate_sel == `ASU_RATE_TIMER) begin
         limit = (match_val == 8'h00) ? 16'h0000 :
                 {8'h00, match_val - 8'h01};
      end else begin
         run = 1'b0; // unused code stops the link rather than guess
      end
      tick    = run && (cnt_ff >= limit);
      nxt_cnt = (tick || !run) ? 16'h0000 : cnt_ff + 16'h0001;
   end

   // divider counter
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

// File: hw/asu_rx_filter.sv
// receive line noise rejection: a level must hold before it is passed
// assumes: din is synchronous to clock
`timescale 1ns/1ns
`include "asu_regs.svh"
module asu_rx_filter (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // filter selection and line
   input  wire logic [1:0] mode,
   input  wire logic       din,
   output logic            dout
);
   asu_pkg::asu_flt_t s_ff;
   asu_pkg::asu_flt_t nxt_s;
   logic [6:0]        thr;

   // unless mode is 00, which passes the line through, pulses shorter than the selected width never reach the receiver
   always_comb begin
      nxt_s = s_ff;
      case (mode)
         2'b01:   thr = `ASU_FLT_SHORT;
         2'b10:   thr = `ASU_FLT_MID;
         default: thr = `ASU_FLT_LONG;
      endcase
      if (mode == 2'b00 || din == s_ff.out) begin
         nxt_s.cnt = 7'h00;
         nxt_s.out = din;
      end else if (s_ff.cnt >= thr - 7'h01) begin
         nxt_s.cnt = 7'h00;
         nxt_s.out = din;
      end else begin
         nxt_s.cnt = s_ff.cnt + 7'h01;
      end
   end

   // state register, line idles high
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_ff <= '{cnt: 7'h00, out: 1'b1};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign dout = s_ff.out;
endmodule

// File: hw/asu_uart.sv
// asynchronous serial transceiver with one-byte holding buffers
// assumes: APB master in the clock domain; serial_in synchronous
`timescale 1ns/1ns
`include "asu_regs.svh"
module asu_uart #(
   parameter logic [15:0] BASE_DIV = 16'(`ASU_BASE_DIV)
) (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // register bus
   input  asu_pkg::asu_apb_req_t    apb_req,
   output asu_pkg::asu_apb_rsp_t    apb_rsp,
   // serial line
   input  wire logic                serial_in,
   output logic                     serial_out,
   // event pulses
   output logic                     tx_irq,
   output logic                     rx_irq
);
   asu_pkg::asu_state_t s_ff;
   asu_pkg::asu_state_t nxt_s;
   asu_pkg::asu_sel_t   sel;
   logic                tick;
   logic                line_in;
   logic                acc;
   logic                maj;
   logic                tx_fin;
   logic                rx_fin;
   logic                fbad_now;
   logic [3:0]          rx_os_n;

   // address decode, byte address is four times the register index
   function automatic asu_pkg::asu_sel_t dec(input logic [7:0] a);
      asu_pkg::asu_sel_t r;
      r = asu_pkg::ASU_SEL_NONE;
      if (a[1:0] != 2'b00) begin
         r = asu_pkg::ASU_SEL_NONE;
      end else if (a[7:2] == `ASU_IDX_CTRL1) begin
         r = asu_pkg::ASU_SEL_C1;
      end else if (a[7:2] == `ASU_IDX_STATUS) begin
         r = asu_pkg::ASU_SEL_SR;
      end else if (a[7:2] == `ASU_IDX_CTRL2) begin
         r = asu_pkg::ASU_SEL_C2;
      end else if (a[7:2] == `ASU_IDX_TXHOLD) begin
         r = asu_pkg::ASU_SEL_TXH;
      end else if (a[7:2] == `ASU_IDX_RXHOLD) begin
         r = asu_pkg::ASU_SEL_RXH;
      end else if (a[7:2] == `ASU_IDX_TMATCH) begin
         r = asu_pkg::ASU_SEL_TM;
      end
      return r;
   endfunction

   // parity bit for a byte; even makes the total count of ones even
   function automatic logic par_calc(input logic [7:0] d,
                                     input logic even);
      return even ? ^d : ~^d;
   endfunction

   // two out of three samples decide the bit
   function automatic logic maj3(input logic [2:0] v);
      return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
   endfunction

   // oversample tick source
   asu_baud_gen #(
      .BASE_DIV (BASE_DIV)
   ) i_asu_baud_gen (
      .clock     (clock),
      .rst_n     (rst_n),
      .rate_sel  (s_ff.lcr1[2:0]),
      .match_val (s_ff.tmv),
      .tick      (tick)
   );

   // receive line noise rejection
   asu_rx_filter i_asu_rx_filter (
      .clock (clock),
      .rst_n (rst_n),
      .mode  (s_ff.lcr2[`ASU_C2_FLT_HI:`ASU_C2_FLT_LO]),
      .din   (serial_in),
      .dout  (line_in)
   );

   assign sel = dec(apb_req.paddr);
   assign acc = apb_req.psel && apb_req.penable;

   // zero wait state slave: data is captured in setup, answered in access
   assign apb_rsp.pready  = acc;
   assign apb_rsp.pslverr = acc && s_ff.err;
   assign apb_rsp.prdata  = s_ff.rdata;
   assign serial_out      = s_ff.out;
   assign tx_irq          = s_ff.tx_irq;
   assign rx_irq          = s_ff.rx_irq;

   // next state: bus effects first, hardware sets afterwards so sets win
   always_comb begin
      nxt_s        = s_ff;
      nxt_s.tx_irq = 1'b0;
      nxt_s.rx_irq = 1'b0;
      tx_fin       = 1'b0;
      rx_fin       = 1'b0;
      maj          = maj3({s_ff.rx_smp, line_in});
      fbad_now     = s_ff.rx_fbad | ~maj;
      rx_os_n      = s_ff.rx_os + 4'h1;

      // setup phase: snapshot read data and the error answer
      if (apb_req.psel && !apb_req.penable) begin
         nxt_s.err   = (sel == asu_pkg::ASU_SEL_NONE) ||
                       (apb_req.pwrite && (sel == asu_pkg::ASU_SEL_SR ||
                                           sel == asu_pkg::ASU_SEL_RXH));
         nxt_s.rdata = 32'h0000_0000;
         case (sel)
            asu_pkg::ASU_SEL_C1:  nxt_s.rdata[7:0] = s_ff.lcr1;
            asu_pkg::ASU_SEL_C2:  nxt_s.rdata[7:0] = s_ff.lcr2;
            asu_pkg::ASU_SEL_TM:  nxt_s.rdata[7:0] = s_ff.tmv;
            asu_pkg::ASU_SEL_TXH: nxt_s.rdata[7:0] = s_ff.tx_hold;
            asu_pkg::ASU_SEL_RXH: nxt_s.rdata[7:0] = s_ff.rx_hold;
            asu_pkg::ASU_SEL_SR:  nxt_s.rdata[7:0] =
               {s_ff.pbad, s_ff.fbad, s_ff.oerr, s_ff.rbfl,
                s_ff.done, s_ff.tbmt, 2'b00};
            default:              nxt_s.rdata = 32'h0000_0000;
         endcase
      end

      // access phase writes; an erroring access changes nothing
      if (acc && apb_req.pwrite && !s_ff.err) begin
         if (sel == asu_pkg::ASU_SEL_C1) begin
            nxt_s.lcr1 = apb_req.pwdata[7:0];
         end else if (sel == asu_pkg::ASU_SEL_C2) begin
            nxt_s.lcr2 = apb_req.pwdata[7:0];
         end else if (sel == asu_pkg::ASU_SEL_TM) begin
            nxt_s.tmv = apb_req.pwdata[7:0];
         end else if (sel == asu_pkg::ASU_SEL_TXH) begin
            nxt_s.arm_tx = 1'b0;
            if (s_ff.arm_tx && s_ff.tbmt) begin
               nxt_s.tx_hold = apb_req.pwdata[7:0];
               nxt_s.tbmt    = 1'b0;
            end
         end
      end

      // access phase reads with side effects
      if (acc && !apb_req.pwrite && !s_ff.err) begin
         if (sel == asu_pkg::ASU_SEL_SR) begin
            nxt_s.arm_tx    = 1'b1;
            nxt_s.arm_rx    = 1'b1;
            nxt_s.oerr_seen = s_ff.rdata[`ASU_SR_OERR];
         end else if (sel == asu_pkg::ASU_SEL_RXH && s_ff.arm_rx) begin
            nxt_s.arm_rx = 1'b0;
            nxt_s.pbad   = 1'b0;
            nxt_s.fbad   = 1'b0;
            nxt_s.rbfl   = 1'b0;
            if (s_ff.oerr_seen) begin
               nxt_s.oerr = 1'b0;
            end
         end
      end

      // transmitter; the line idles high outside frames
      if (s_ff.tx_st == asu_pkg::ASU_IDLE) begin
         nxt_s.out = 1'b1;
         if (!s_ff.tbmt && s_ff.lcr1[`ASU_C1_TXEN]) begin
            nxt_s.tx_st  = asu_pkg::ASU_START;
            nxt_s.tx_os  = 4'h0;
            nxt_s.tx_sh  = s_ff.tx_hold;
            nxt_s.tx_par = par_calc(s_ff.tx_hold,
                                    s_ff.lcr1[`ASU_C1_EVEN]);
            nxt_s.out    = 1'b0;
            nxt_s.tbmt   = 1'b1;
            nxt_s.tx_irq = 1'b1;
            nxt_s.done   = 1'b0;
         end
      end else if (tick) begin
         nxt_s.tx_os = s_ff.tx_os + 4'h1;
         if (s_ff.tx_os == `ASU_OS_END) begin
            case (s_ff.tx_st)
               asu_pkg::ASU_START: begin
                  nxt_s.tx_st  = asu_pkg::ASU_DATA;
                  nxt_s.tx_bit = 3'h0;
                  nxt_s.out    = s_ff.tx_sh[0];
               end
               asu_pkg::ASU_DATA: begin
                  nxt_s.tx_sh = {1'b0, s_ff.tx_sh[7:1]};
                  if (s_ff.tx_bit != 3'h7) begin
                     nxt_s.tx_bit = s_ff.tx_bit + 3'h1;
                     nxt_s.out    = s_ff.tx_sh[1];
                  end else if (s_ff.lcr1[`ASU_C1_PARON]) begin
                     nxt_s.tx_st = asu_pkg::ASU_PAR;
                     nxt_s.out   = s_ff.tx_par;
                  end else begin
                     nxt_s.tx_st  = asu_pkg::ASU_STOP;
                     nxt_s.tx_bit = 3'h0;
                     nxt_s.out    = 1'b1;
                  end
               end
               asu_pkg::ASU_PAR: begin
                  nxt_s.tx_st  = asu_pkg::ASU_STOP;
                  nxt_s.tx_bit = 3'h0;
                  nxt_s.out    = 1'b1;
               end
               default: begin
                  if (s_ff.lcr1[`ASU_C1_STOP2] && s_ff.tx_bit == 3'h0) begin
                     nxt_s.tx_bit = 3'h1;
                  end else begin
                     nxt_s.tx_st = asu_pkg::ASU_IDLE;
                     tx_fin      = 1'b1;
                     if (nxt_s.tbmt) begin
                        nxt_s.done = 1'b1;
                     end
                  end
               end
            endcase
         end
      end

      // receiver; a new start is taken only while enabled and no overrun
      if (s_ff.rx_st == asu_pkg::ASU_IDLE) begin
         if (tick && s_ff.lcr1[`ASU_C1_RXEN] && !s_ff.oerr &&
             !line_in) begin
            nxt_s.rx_st   = asu_pkg::ASU_START;
            nxt_s.rx_os   = 4'h0;
            nxt_s.rx_pbad = 1'b0;
            nxt_s.rx_fbad = 1'b0;
         end
      end else if (tick) begin
         nxt_s.rx_os = rx_os_n;
         if (s_ff.rx_os >= `ASU_OS_FIRST && s_ff.rx_os < `ASU_OS_LAST) begin
            nxt_s.rx_smp = {s_ff.rx_smp[0], line_in};
         end
         case (s_ff.rx_st)
            asu_pkg::ASU_START: begin
               if (s_ff.rx_os == `ASU_OS_LAST && maj) begin
                  nxt_s.rx_st = asu_pkg::ASU_IDLE; // glitch, not a start
               end else if (s_ff.rx_os == `ASU_OS_END) begin
                  nxt_s.rx_st  = asu_pkg::ASU_DATA;
                  nxt_s.rx_bit = 3'h0;
               end
            end
            asu_pkg::ASU_DATA: begin
               if (s_ff.rx_os == `ASU_OS_LAST) begin
                  nxt_s.rx_sh = {maj, s_ff.rx_sh[7:1]};
               end else if (s_ff.rx_os == `ASU_OS_END) begin
                  if (s_ff.rx_bit != 3'h7) begin
                     nxt_s.rx_bit = s_ff.rx_bit + 3'h1;
                  end else if (s_ff.lcr1[`ASU_C1_PARON]) begin
                     nxt_s.rx_st = asu_pkg::ASU_PAR;
                  end else begin
                     nxt_s.rx_st  = asu_pkg::ASU_STOP;
                     nxt_s.rx_bit = 3'h0;
                  end
               end
            end
            asu_pkg::ASU_PAR: begin
               if (s_ff.rx_os == `ASU_OS_LAST) begin
                  nxt_s.rx_pbad = maj ^ par_calc(s_ff.rx_sh,
                                     s_ff.lcr1[`ASU_C1_EVEN]);
               end else if (s_ff.rx_os == `ASU_OS_END) begin
                  nxt_s.rx_st  = asu_pkg::ASU_STOP;
                  nxt_s.rx_bit = 3'h0;
               end
            end
            default: begin
               if (s_ff.rx_os == `ASU_OS_LAST) begin
                  nxt_s.rx_fbad = fbad_now;
                  if (s_ff.lcr2[`ASU_C2_RXSTOP2] &&
                      s_ff.rx_bit == 3'h0) begin
                     nxt_s.rx_bit = 3'h1;
                  end else begin
                     // finish at mid stop so the next start is not missed
                     nxt_s.rx_st = asu_pkg::ASU_IDLE;
                     rx_fin      = 1'b1;
                  end
               end
            end
         endcase
      end

      // frame complete: deliver or flag overrun; sets beat the read clear
      if (rx_fin) begin
         if (s_ff.rbfl) begin
            nxt_s.oerr = 1'b1;
         end else begin
            nxt_s.rx_hold = s_ff.rx_sh;
            nxt_s.rbfl    = 1'b1;
            nxt_s.rx_irq  = 1'b1;
            nxt_s.pbad    = s_ff.rx_pbad;
            nxt_s.fbad    = fbad_now;
         end
      end
   end

   // single state register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_ff         <= '0;
         s_ff.lcr1    <= `ASU_CTRL1_RST;
         s_ff.lcr2    <= `ASU_CTRL2_RST;
         s_ff.tmv     <= `ASU_TMATCH_RST;
         s_ff.tx_st   <= asu_pkg::ASU_IDLE;
         s_ff.rx_st   <= asu_pkg::ASU_IDLE;
         s_ff.out     <= 1'b1;
         s_ff.done    <= 1'b1;
         s_ff.tbmt    <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // checks on the transmitter
   a_tx_idle_high: assert property (@(posedge clock) disable iff (!rst_n)
      !s_ff.lcr1[`ASU_C1_TXEN] && s_ff.tx_st == asu_pkg::ASU_IDLE
      |=> serial_out)
      else $error("serial_out low while transmitter disabled");
   a_tx_write_load: assert property (@(posedge clock) disable iff (!rst_n)
      acc && apb_req.pwrite && sel == asu_pkg::ASU_SEL_TXH && !s_ff.err &&
      s_ff.arm_tx && s_ff.tbmt |=> !s_ff.tbmt)
      else $error("armed holding write did not clear empty flag");
   a_tx_start_irq: assert property (@(posedge clock) disable iff (!rst_n)
      s_ff.tx_st == asu_pkg::ASU_IDLE && !s_ff.tbmt &&
      s_ff.lcr1[`ASU_C1_TXEN]
      |=> s_ff.tbmt && tx_irq && !serial_out ##1 !tx_irq)
      else $error("transmit start did not set empty and pulse irq");
   a_tx_unarmed: assert property (@(posedge clock) disable iff (!rst_n)
      acc && apb_req.pwrite && sel == asu_pkg::ASU_SEL_TXH &&
      !s_ff.arm_tx && s_ff.tbmt && s_ff.tx_st == asu_pkg::ASU_IDLE
      |=> s_ff.tbmt && $stable(s_ff.tx_hold) && !tx_irq)
      else $error("unarmed holding write was accepted");
   a_tx_done_flag: assert property (@(posedge clock) disable iff (!rst_n)
      tx_fin && nxt_s.tbmt |=> s_ff.done && serial_out)
      else $error("done flag not set at frame end");

   // checks on the receiver
   a_rx_deliver: assert property (@(posedge clock) disable iff (!rst_n)
      rx_fin && !s_ff.rbfl
      |=> rx_irq && s_ff.rbfl && s_ff.rx_hold == $past(s_ff.rx_sh))
      else $error("received byte not delivered");
   a_rx_overrun: assert property (@(posedge clock) disable iff (!rst_n)
      rx_fin && s_ff.rbfl
      |=> s_ff.oerr && !rx_irq && $stable(s_ff.rx_hold))
      else $error("overrun not flagged or holding overwritten");
   a_rx_inhibit: assert property (@(posedge clock) disable iff (!rst_n)
      s_ff.oerr && s_ff.rx_st == asu_pkg::ASU_IDLE
      |=> s_ff.rx_st == asu_pkg::ASU_IDLE)
      else $error("reception started during overrun");
   a_rx_clear: assert property (@(posedge clock) disable iff (!rst_n)
      acc && !apb_req.pwrite && sel == asu_pkg::ASU_SEL_RXH &&
      !s_ff.err && s_ff.arm_rx && !rx_fin
      |=> !s_ff.rbfl && !s_ff.pbad && !s_ff.fbad)
      else $error("armed holding read did not clear flags");
   a_oerr_late: assert property (@(posedge clock) disable iff (!rst_n)
      acc && !apb_req.pwrite && sel == asu_pkg::ASU_SEL_RXH &&
      s_ff.arm_rx && !s_ff.oerr_seen && s_ff.oerr |=> s_ff.oerr)
      else $error("late overrun cleared by holding read alone");
endmodule

// File: bench/asu_line_partner.sv
// far-side serial model: sends framed bytes, decodes transmitted ones
// assumes: one bit lasts BIT clocks; the line idles high between frames
`timescale 1ns/1ns
module asu_line_partner #(
   parameter int BIT = 64
) (
   // clock
   input  wire logic       clock,
   // send request and format
   input  wire logic       send,
   input  wire logic [7:0] data,
   input  wire logic       par_on,
   input  wire logic       bad,
   // serial lines and decoded byte
   input  wire logic       line_in,
   output logic            line_out,
   output logic            busy,
   output logic [7:0]      got
);
   int i;
   int k;
   initial begin
      line_out = 1'b1;
      busy = 1'b0;
      got = 8'h00;
   end
   // bad flips even parity and drops the stop bit low
   always @(posedge clock) begin
      if (send) begin
         busy <= 1'b1;
         line_out <= 1'b0;
         repeat (BIT) @(posedge clock);
         for (i = 0; i < 8; i++) begin
            line_out <= data[i];
            repeat (BIT) @(posedge clock);
         end
         if (par_on) begin
            line_out <= (^data) ^ bad;
            repeat (BIT) @(posedge clock);
         end
         line_out <= ~bad;
         repeat (BIT) @(posedge clock);
         line_out <= 1'b1;
         repeat (BIT) @(posedge clock);
         busy <= 1'b0;
      end
   end
   // mid-bit sampling is immune to the short first start bit
   always begin
      @(negedge line_in);
      repeat (BIT / 2) @(posedge clock);
      for (k = 0; k < 8; k++) begin
         repeat (BIT) @(posedge clock);
         got[k] = line_in;
      end
      repeat (BIT) @(posedge clock);
   end
endmodule

// File: bench/async_serial_uart_test.sv
// self-checking bench: APB register tasks plus a serial partner
// assumes: BASE_DIV of 4 at rate code 0 gives 64 clocks per bit
`timescale 1ns/1ns
`include "asu_regs.svh"
module async_serial_uart_test;
   localparam int         BIT = 64;
   localparam logic [7:0] C1  = {`ASU_IDX_CTRL1, 2'b00};
   localparam logic [7:0] SR  = {`ASU_IDX_STATUS, 2'b00};
   localparam logic [7:0] C2  = {`ASU_IDX_CTRL2, 2'b00};
   localparam logic [7:0] TXH = {`ASU_IDX_TXHOLD, 2'b00};
   localparam logic [7:0] RXH = {`ASU_IDX_RXHOLD, 2'b00};
   localparam logic [7:0] TM  = {`ASU_IDX_TMATCH, 2'b00};
   logic                  clock = 1'b0;
   logic                  rst_n = 1'b0;
   asu_pkg::asu_apb_req_t req = '0;
   asu_pkg::asu_apb_rsp_t rsp;
   logic                  line_rx;
   logic                  serial_out;
   logic                  tx_irq;
   logic                  rx_irq;
   logic                  send = 1'b0;
   logic                  bad = 1'b0;
   logic                  par_on = 1'b0;
   logic                  busy;
   logic [7:0]            pdat = 8'h00;
   logic [7:0]            got;
   logic [31:0]           rdat;
   logic                  rerr;
   int                    err_count = 0;
   int                    checks = 0;
   int                    ntx = 0;
   int                    nrx = 0;

   asu_uart #(.BASE_DIV(16'h0004)) i_asu_uart (.clock(clock),
      .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .serial_in(line_rx),
      .serial_out(serial_out), .tx_irq(tx_irq), .rx_irq(rx_irq));
   asu_line_partner #(.BIT(BIT)) i_asu_line_partner (.clock(clock),
      .send(send), .data(pdat), .par_on(par_on), .bad(bad),
      .line_in(serial_out), .line_out(line_rx), .busy(busy), .got(got));

   // clock and event pulse counters
   always #2 clock = ~clock;
   always @(posedge clock) begin
      if (tx_irq === 1'b1) ntx++;
      if (rx_irq === 1'b1) nrx++;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask

   // one APB transfer; read data taken at the edge that sees pready
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
      @(posedge clock);
      req.penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req <= '0;
      if (n >= 20) begin
         err_count++;
         print_verdict();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 8'h00);
      chk(rdat, e);
   endtask

   // partner frame; returns once the line is idle again
   task automatic frame(input logic [7:0] d, input logic b);
      int n;
      n = 0;
      @(posedge clock);
      pdat <= d;
      bad <= b;
      send <= 1'b1;
      @(posedge clock);
      send <= 1'b0;
      do begin
         @(posedge clock);
         n++;
      end while (busy === 1'b1 && n < 2000);
      if (n >= 2000) begin
         err_count++;
         print_verdict();
      end
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge clock);
      err_count++;
      print_verdict();
   end

   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rd(SR, 32'h0c);
      rd(C1, 32'h00);
      rd(C2, 32'h00);
      rd(TM, 32'h01);
      rd(8'hfc, 32'h00);
      chk({31'h0, rerr}, 32'h1);
      $display("test registers done");
      xfer(1'b1, TXH, 8'h5a);
      rd(SR, 32'h08);
      xfer(1'b1, TXH, 8'h77);
      chk({31'h0, serial_out}, 32'h1);
      xfer(1'b1, C1, 8'hc0);
      repeat (12 * BIT) @(posedge clock);
      chk({24'h0, got}, 32'h5a);
      xfer(1'b1, TXH, 8'h33);
      repeat (BIT) @(posedge clock);
      chk({31'h0, serial_out}, 32'h1);
      rd(SR, 32'h0c);
      chk(32'(ntx), 32'h1);
      xfer(1'b1, TXH, 8'h33);
      repeat (BIT) @(posedge clock);
      rd(SR, 32'h04);
      repeat (12 * BIT) @(posedge clock);
      chk({24'h0, got}, 32'h33);
      chk(32'(ntx), 32'h2);
      $display("test transmit done");
      frame(8'h3c, 1'b0);
      chk(32'(nrx), 32'h1);
      rd(SR, 32'h1c);
      frame(8'h11, 1'b0);
      rd(SR, 32'h3c);
      frame(8'h22, 1'b0);
      chk(32'(nrx), 32'h1);
      rd(RXH, 32'h3c);
      rd(SR, 32'h0c);
      $display("test overrun done");
      par_on <= 1'b1;
      xfer(1'b1, C1, 8'hd8);
      xfer(1'b1, C2, 8'h08);
      rd(C2, 32'h08);
      frame(8'h3c, 1'b1);
      rd(SR, 32'hdc);
      rd(RXH, 32'h3c);
      rd(SR, 32'h0c);
      chk(32'(nrx), 32'h2);
      $display("test errors done");
      frame(8'h55, 1'b0);
      frame(8'h66, 1'b0);
      chk(32'(nrx), 32'h3);
      rd(RXH, 32'h55);
      rd(SR, 32'h2c);
      rd(RXH, 32'h55);
      rd(SR, 32'h0c);
      $display("test late overrun done");
      print_verdict();
   end
endmodule
